// ---- rtl/mdj_pkg.sv ----
// Package of the machine data job checker: register map, job numbers,
// answer codes, bus carriers and the block state.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
`default_nettype none
package mdj_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_JOB = 8'h04;
    localparam logic [7:0] A_BRU = 8'h08;
    localparam logic [7:0] A_VAL0 = 8'h0C;
    localparam logic [7:0] A_VAL7 = 8'h28;
    localparam logic [7:0] A_AXST = 8'h2C;
    localparam logic [7:0] A_DEPS = 8'h30;
    localparam logic [7:0] A_DATA = 8'h34;
    localparam logic [7:0] A_REPLY = 8'h38;
    localparam logic [7:0] A_IRQST = 8'h3C;
    localparam logic [7:0] A_IRQMSK = 8'h40;
    // ----------------------------------------
    // Staged machine data slots and modes
    // ----------------------------------------
    localparam int V_TGT = 0;
    localparam int V_WORK = 1;
    localparam int V_FCUT = 2;
    localparam int V_FCHG = 3;
    localparam int V_RCUT = 4;
    localparam int V_RCHG = 5;
    localparam int V_FADP = 6;
    localparam int V_RADP = 7;
    localparam logic [1:0] M_CPU = 2'h1;
    localparam logic [1:0] M_PU = 2'h2;
    // ----------------------------------------
    // Job numbers and answer codes
    // ----------------------------------------
    localparam logic [7:0] J_OUT = 8'h40;
    localparam logic [7:0] J_IN = 8'h41;
    localparam logic [7:0] J_DEL = 8'h42;
    localparam logic [7:0] C_OK = 8'h00;
    localparam logic [7:0] C_RCUT = 8'h3A;
    localparam logic [7:0] C_FADP = 8'h3B;
    localparam logic [7:0] C_RADP = 8'h3C;
    localparam logic [7:0] C_DISC = 8'h46;
    localparam logic [7:0] C_JOB = 8'hC8;
    localparam logic [7:0] C_NODS = 8'hFA;
    localparam logic [7:0] C_CPU = 8'hFB;
    localparam logic [7:0] C_PU = 8'hFD;
    localparam logic [7:0] C_CHG = 8'hFE;
    localparam logic [7:0] C_DEL = 8'hFF;
    // ----------------------------------------
    // Limits, reset values, response codes
    // ----------------------------------------
    localparam logic signed [63:0] LIM_MULT = 64'sh0000_0000_05F5_E100;
    localparam logic [31:0] BRU_RST = 32'h0000_0001;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_DISC = 2;
    // ----------------------------------------
    // Bus carriers and block state
    // ----------------------------------------
    typedef struct packed {
        logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr;
        logic rready;
    } mdj_axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } mdj_axi_rsp_t;
    typedef struct packed {
        mdj_axi_rsp_t rsp;
        logic awHave; logic [7:0] awAddr; logic wHave; logic [31:0] wData;
        logic [3:0] wStrb; logic [2:0] ctrl; logic [31:0] bru;
        logic [7:0][31:0] val; logic [8:0] axState; logic [2:0][7:0] deps;
        logic [2:0] hasData; logic [2:0][7:0] dsNum; logic [7:0] code;
        logic [7:0] discard; logic [2:0] irqSt; logic [2:0] irqMask; logic irq;
    } mdj_state_t;
endpackage
`default_nettype wire

// ---- rtl/mdj_checker.sv ----
// Machine data job checker with an AXI4-Lite register slave.
// Assumes a single 125 MHz clock and a synchronous active-low reset.
//
// What this block does
// - Reverse cutoff difference outside 1..1e8 units, not below reverse changeover, or not above target plus adaption on a linear axis answers 58.
// - A forward adaption magnitude above 1e8 units answers 59.
// - Forward cutoff plus forward adaption not above target range answers 59.
// - On a linear axis forward changeover plus forward adaption not below working range answers 59.
// - A reverse adaption magnitude above 1e8 units answers 60.
// - Reverse cutoff plus reverse adaption not above target range answers 60.
// - On a linear axis reverse changeover plus reverse adaption not below working range answers 60.
// - Accepted machine data that discards dependent sets answers 70 with the discarded count in the reply.
// - Only jobs 64, 65 and 66 are taken, any other answers 200.
// - Reading or deleting a data set number held by no axis, or entry onto axis 3, answers 250.
// - Entry or deletion from the CPU outside CPU mode answers 251.
// - Entry or deletion from the programming unit outside its mode answers 253.
// - A change while the axis is not completed or still interpreting answers 254.
// - Deletion while the axis is not completed answers 255.
// - Deleting a leading axis set while its parallel axis holds a set answers 255.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
module mdj_checker
    import mdj_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire mdj_axi_req_t axiReq,
    output mdj_axi_rsp_t axiRsp,
    output logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic signed [63:0] sx(input logic [31:0] v);
        sx = {{32{v[31]}}, v};
    endfunction

    function automatic logic signed [63:0] mag(input logic signed [63:0] v);
        mag = v[63] ? -v : v;
    endfunction

    // Byte enables pick lanes of the new word over the old
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = n[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic [1:0] nextAx(input logic [1:0] a);
        nextAx = (a == 2'h2) ? 2'h0 : a + 2'h1;
    endfunction

    mdj_state_t q, d;

    // ----------------------------------------
    // Job decode from the pending write word
    // ----------------------------------------
    logic [7:0] jn, ds, jobCode;
    logic pu, lin, found, jobGo, modeBad, bad58, bad59, bad60;
    logic [1:0] ax, fAx;
    logic [2:0] comp, interp, lead;
    logic signed [63:0] lim, one, tgt, work, fc, fchg, rc, rchg, fa, ra;

    assign jobGo = q.awHave && q.wHave && !q.rsp.bvalid && q.awAddr == A_JOB;
    assign jn = q.wData[7:0];
    assign ds = q.wData[15:8];
    assign pu = q.wData[16];
    assign ax = q.wData[18:17];
    assign lin = q.ctrl[2];
    assign comp = q.axState[2:0];
    assign interp = q.axState[5:3];
    assign lead = q.axState[8:6];
    // Limits are multiples of the resolution unit in wide signed form
    assign one = sx(q.bru);
    assign lim = one * LIM_MULT;
    assign tgt = sx(q.val[V_TGT]);
    assign work = sx(q.val[V_WORK]);
    assign fc = sx(q.val[V_FCUT]);
    assign fchg = sx(q.val[V_FCHG]);
    assign rc = sx(q.val[V_RCUT]);
    assign rchg = sx(q.val[V_RCHG]);
    assign fa = sx(q.val[V_FADP]);
    assign ra = sx(q.val[V_RADP]);

    // Reverse cutoff window and ordering
    assign bad58 = rc < one || rc > lim || !(rc < rchg) || (lin && !(rc > tgt + ra));
    // Forward adaption size and sums
    assign bad59 = mag(fa) > lim || !(fc + fa > tgt) || (lin && !(fchg + fa < work));
    // Reverse adaption size and sums
    assign bad60 = mag(ra) > lim || !(rc + ra > tgt) || (lin && !(rchg + ra < work));

    // Entry or deletion needs the mode matching the requester
    assign modeBad = jn != J_OUT && (pu ? q.ctrl[1:0] != M_PU : q.ctrl[1:0] != M_CPU);

    // Axis holding the named data set; lowest index wins
    always_comb begin
        found = 1'b0;
        fAx = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (q.hasData[i] && q.dsNum[i] == ds) begin
                found = 1'b1;
                fAx = 2'(i);
            end
        end
    end

    // Fixed evaluation order; first failure alone is reported
    always_comb begin
        jobCode = C_OK;
        if (jn != J_OUT && jn != J_IN && jn != J_DEL) begin
            jobCode = C_JOB;
        end else if (modeBad) begin
            jobCode = pu ? C_PU : C_CPU;
        end else if (jn == J_IN) begin
            if (ax == 2'h3) begin
                jobCode = C_NODS; // No such axis
            end else if (!comp[ax] || interp[ax]) begin
                jobCode = C_CHG;
            end else if (bad58) begin
                jobCode = C_RCUT;
            end else if (bad59) begin
                jobCode = C_FADP;
            end else if (bad60) begin
                jobCode = C_RADP;
            end else if (q.deps[ax] != 8'h00) begin
                jobCode = C_DISC;
            end
        end else if (!found) begin
            jobCode = C_NODS;
        end else if (jn == J_DEL && (!comp[fAx] || (lead[fAx] && q.hasData[nextAx(fAx)]))) begin
            jobCode = C_DEL;
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    logic [31:0] rdWord;
    logic rdHit;

    always_comb begin
        rdHit = 1'b1;
        rdWord = 32'h0000_0000;
        case (axiReq.araddr)
            A_CTRL: rdWord = {29'h0, q.ctrl};
            A_BRU: rdWord = q.bru;
            A_AXST: rdWord = {23'h0, q.axState};
            A_DEPS: rdWord = {8'h00, q.deps};
            A_DATA: rdWord = {q.dsNum, 5'h00, q.hasData};
            A_REPLY: rdWord = {16'h0000, q.discard, q.code};
            A_IRQST: rdWord = {29'h0, q.irqSt};
            A_IRQMSK: rdWord = {29'h0, q.irqMask};
            A_JOB: rdWord = 32'h0000_0000; // Job word is write-only
            default: begin
                if (axiReq.araddr >= A_VAL0 && axiReq.araddr <= A_VAL7 && axiReq.araddr[1:0] == 2'h0) begin
                    rdWord = q.val[3'((axiReq.araddr - A_VAL0) >> 2)];
                end else begin
                    rdHit = 1'b0;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Next state: bus handshakes, register writes, jobs
    // ----------------------------------------
    logic [2:0] ev;
    logic wrGo;

    assign wrGo = q.awHave && q.wHave && !q.rsp.bvalid;

    always_comb begin
        d = q;
        ev = 3'h0;
        // Address and data are caught in either order
        if (axiReq.awvalid && q.rsp.awready) begin
            d.awHave = 1'b1;
            d.awAddr = axiReq.awaddr;
            d.rsp.awready = 1'b0;
        end
        if (axiReq.wvalid && q.rsp.wready) begin
            d.wHave = 1'b1;
            d.wData = axiReq.wdata;
            d.wStrb = axiReq.wstrb;
            d.rsp.wready = 1'b0;
        end
        if (q.rsp.bvalid && axiReq.bready) begin
            d.rsp.bvalid = 1'b0;
            d.rsp.awready = 1'b1;
            d.rsp.wready = 1'b1;
        end
        if (wrGo) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = RESP_OK;
            case (q.awAddr)
                A_CTRL: d.ctrl = 3'(merge({29'h0, q.ctrl}, q.wData, q.wStrb));
                A_BRU: d.bru = merge(q.bru, q.wData, q.wStrb);
                A_AXST: d.axState = 9'(merge({23'h0, q.axState}, q.wData, q.wStrb));
                A_DEPS: d.deps = 24'(merge({8'h00, q.deps}, q.wData, q.wStrb));
                A_IRQMSK: d.irqMask = 3'(merge({29'h0, q.irqMask}, q.wData, q.wStrb));
                A_IRQST: d.irqSt = q.irqSt & ~q.wData[2:0]; // Write one to clear
                A_DATA, A_REPLY: d.rsp.bresp = RESP_ERR; // Read-only
                A_JOB: begin
                    d.code = jobCode;
                    d.discard = 8'h00;
                    ev[IRQ_DONE] = 1'b1;
                    // Stored sets change only on success
                    if (jn == J_IN && (jobCode == C_OK || jobCode == C_DISC)) begin
                        d.hasData[ax] = 1'b1;
                        d.dsNum[ax] = ds;
                    end
                    // Discarded count lands in the reply mailbox
                    if (jobCode == C_DISC) begin
                        d.discard = q.deps[ax];
                        d.deps[ax] = 8'h00;
                        ev[IRQ_DISC] = 1'b1;
                    end
                    if (jn == J_DEL && jobCode == C_OK) begin
                        d.hasData[fAx] = 1'b0;
                    end
                    ev[IRQ_ERR] = jobCode != C_OK && jobCode != C_DISC;
                end
                default: begin
                    if (q.awAddr >= A_VAL0 && q.awAddr <= A_VAL7 && q.awAddr[1:0] == 2'h0) begin
                        d.val[3'((q.awAddr - A_VAL0) >> 2)] =
                            merge(q.val[3'((q.awAddr - A_VAL0) >> 2)], q.wData, q.wStrb);
                    end else begin
                        d.rsp.bresp = RESP_ERR;
                    end
                end
            endcase
        end
        // Events override a clear in the same cycle so none is lost
        d.irqSt = d.irqSt | ev;
        d.irq = |(d.irqSt & d.irqMask);
        // Read channel: one outstanding read
        if (q.rsp.rvalid && axiReq.rready) begin
            d.rsp.rvalid = 1'b0;
            d.rsp.arready = 1'b1;
        end
        if (axiReq.arvalid && q.rsp.arready) begin
            d.rsp.arready = 1'b0;
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata = rdWord;
            d.rsp.rresp = rdHit ? RESP_OK : RESP_ERR;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.bru <= BRU_RST;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign axiRsp = q.rsp;
    assign irq = q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    bad_job_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jn != J_OUT && jn != J_IN && jn != J_DEL) |=> q.code == 8'hC8 && q.irqSt[IRQ_ERR])
        else $error("unknown job not answered with 200");

    cpu_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && (jn == J_IN || jn == J_DEL) && !pu && q.ctrl[1:0] != M_CPU) |=> q.code == 8'hFB)
        else $error("CPU entry outside CPU mode not refused");

    pu_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && (jn == J_IN || jn == J_DEL) && pu && q.ctrl[1:0] != M_PU) |=> q.code == 8'hFD)
        else $error("programming unit entry outside its mode not refused");

    no_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jn == J_OUT && !(|(q.hasData))) |=> q.code == 8'hFA)
        else $error("missing data set not answered with 250");

    busy_axis_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jn == J_IN && !modeBad && ax != 2'h3 && interp[ax]) |=> q.code == 8'hFE)
        else $error("change on interpreting axis not refused");

    keep_data_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jobCode != C_OK && jobCode != C_DISC) |=> q.hasData == $past(q.hasData)
            && q.dsNum == $past(q.dsNum))
        else $error("failed job changed stored data");

    del_block_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jn == J_DEL && !modeBad && found && comp[fAx] && lead[fAx] && q.hasData[nextAx(fAx)])
            |=> q.code == 8'hFF && q.hasData[$past(fAx)])
        else $error("leading axis set deleted while parallel set held");

    discard_cnt_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jobCode == C_DISC) |=> q.code == 8'h46 && q.discard == $past(q.deps[ax])
            && q.irqSt[IRQ_DISC] && q.hasData[$past(ax)] && q.deps[$past(ax)] == 8'h00)
        else $error("discarded count not reported with 70");

    adapt_lim_a: assert property (@(posedge clock) disable iff (!rst_n)
        (jobGo && jn == J_IN && !modeBad && ax != 2'h3 && comp[ax] && !interp[ax] && !bad58
            && mag(fa) > lim) |=> q.code == 8'h3B)
        else $error("oversized forward adaption not answered with 59");

    irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
        (|(q.irqSt & q.irqMask)) == irq)
        else $error("interrupt output disagrees with masked status");
endmodule
`default_nettype wire

// ---- dv/mdj_host.sv ----
// Bus master model for the job checker, standing for the controlling CPU.
// Assumes one clock; a hang is cut short by the bench watchdog.
`default_nettype none
module mdj_host
    import mdj_pkg::*;
(
    input wire logic clock,
    output var mdj_axi_req_t axiReq,
    input wire mdj_axi_rsp_t axiRsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    int lag = 0; // Edges before bready rises, to stall the answer
    initial axiReq = '0;
    // Address and data go out together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        logic done;
        n = 0;
        @(posedge clock);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= v;
        axiReq.wstrb <= 4'hF;
        axiReq.bready <= (lag == 0);
        do begin
            @(posedge clock);
            done = axiReq.bready && (axiRsp.bvalid === 1'b1);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            n++;
            if (n >= lag && !done) axiReq.bready <= 1'b1;
        end while (!done);
        r = axiRsp.bresp;
        axiReq.bready <= 1'b0;
    endtask
    // Read with rready held up from the start
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clock);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        do begin
            @(posedge clock);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1);
        v = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the machine data job checker.
// Assumes the host model drives the register bus; one 125 MHz clock.
`default_nettype none
module testbench
    import mdj_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] bru;
        logic lin;
        int slot;
        logic [31:0] v;
        logic [7:0] c;
    } mdj_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    mdj_axi_req_t axiReq;
    mdj_axi_rsp_t axiRsp;
    logic irq;
    int errCount = 0;
    int checked = 0;
    logic [1:0] r;
    logic [31:0] d;
    logic [31:0] base [8] = '{32'hA, 32'h3E8, 32'h64, 32'hC8, 32'h64, 32'hC8, 32'h0, 32'h0};
    logic [7:0] bad [4] = '{8'h00, 8'h3F, 8'h43, 8'hFF};
    mdj_row_t rows [23] = '{
        '{8'h1, 1'b1, V_RCUT, 32'h0, C_RCUT}, '{8'h1, 1'b1, V_RCUT, 32'hC8, C_RCUT},
        '{8'h1, 1'b1, V_RCUT, 32'hC7, C_OK}, '{8'h1, 1'b1, V_RCUT, 32'hA, C_RCUT},
        '{8'h1, 1'b0, V_RCUT, 32'hA, C_RADP}, '{8'h2, 1'b1, V_RCUT, 32'h1, C_RCUT},
        '{8'h2, 1'b1, V_RCUT, 32'hB, C_OK}, '{8'h1, 1'b0, V_RCUT, 32'h05F5E101, C_RCUT},
        '{8'h1, 1'b0, V_FADP, 32'h05F5E100, C_OK}, '{8'h1, 1'b0, V_FADP, 32'h05F5E101, C_FADP},
        '{8'h2, 1'b0, V_FADP, 32'h05F5E101, C_OK}, '{8'h1, 1'b0, V_FADP, 32'hFFFFFFA6, C_FADP},
        '{8'h1, 1'b0, V_FADP, 32'hFFFFFFA7, C_OK}, '{8'h1, 1'b1, V_FADP, 32'h320, C_FADP},
        '{8'h1, 1'b1, V_FADP, 32'h31F, C_OK}, '{8'h1, 1'b0, V_RADP, 32'hFA0A1EFF, C_RADP},
        '{8'h1, 1'b0, V_RADP, 32'h05F5E100, C_OK}, '{8'h1, 1'b1, V_RADP, 32'h320, C_RCUT},
        '{8'h1, 1'b1, V_TGT, 32'h63, C_OK}, '{8'h1, 1'b1, V_TGT, 32'h64, C_RCUT},
        '{8'h1, 1'b1, V_WORK, 32'hC8, C_FADP}, '{8'h1, 1'b0, V_WORK, 32'hC8, C_OK},
        '{8'h1, 1'b1, V_RCHG, 32'h3E8, C_RADP}};
    // ----------------------------------------
    // Design, host model and clock
    // ----------------------------------------
    mdj_checker u_mdj_checker (.clock(clock), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp), .irq(irq));
    mdj_host u_mdj_host (.clock(clock), .axiReq(axiReq), .axiRsp(axiRsp));
    always #4 clock = ~clock;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] v);
        u_mdj_host.wr(a, v, r);
    endtask
    task automatic rd(input logic [7:0] a);
        u_mdj_host.rd(a, d, r);
    endtask
    // Job word: axis, source, set number, job number
    function automatic logic [31:0] jw(logic [7:0] j, logic [7:0] ds, logic src, logic [1:0] ax);
        return {13'h0, ax, src, ds, j};
    endfunction
    // Issues one job, then reads back the answer code
    task automatic job(input logic [31:0] word, input logic [7:0] c);
        w(A_JOB, word);
        rd(A_REPLY);
        cmp("code", {24'h0, d[7:0]}, {24'h0, c});
    endtask
    // Level is sampled mid-cycle so the registered update has landed
    task automatic chkIrq(input logic e);
        @(negedge clock);
        cmp("irq", {31'h0, irq}, {31'h0, e});
    endtask
    task automatic testDone();
        $display("checks %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #200000;
        errCount++;
        testDone();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        // Table of machine data cases, each a job 65 onto axis 0
        w(A_AXST, 32'h7);
        foreach (rows[i]) begin
            w(A_CTRL, {29'h0, rows[i].lin, M_CPU});
            w(A_BRU, {24'h0, rows[i].bru});
            for (int s = 0; s < 8; s++) w(A_VAL0 + 8'(4 * s), base[s]);
            w(A_VAL0 + 8'(4 * rows[i].slot), rows[i].v);
            job(jw(J_IN, 8'h1, 1'b0, 2'h0), rows[i].c);
        end
        $display("table test done");
        // A reset in mid-run restores the reset values
        @(posedge clock) rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rd(A_BRU);
        cmp("bru", d, BRU_RST);
        rd(A_DATA);
        cmp("data", d, 32'h0);
        rd(8'h80);
        cmp("rresp", {30'h0, r}, {30'h0, RESP_ERR});
        w(A_DATA, 32'hFF);
        cmp("bresp", {30'h0, r}, {30'h0, RESP_ERR});
        $display("reset test done");
        // Job numbers, modes and missing sets
        w(A_AXST, 32'h7);
        for (int s = 0; s < 8; s++) w(A_VAL0 + 8'(4 * s), base[s]);
        foreach (bad[i]) job(jw(bad[i], 8'h1, 1'b0, 2'h0), C_JOB);
        w(A_CTRL, {29'h1, M_PU});
        job(jw(J_IN, 8'h1, 1'b0, 2'h0), C_CPU);
        job(jw(J_DEL, 8'h1, 1'b0, 2'h0), C_CPU);
        job(jw(J_IN, 8'h1, 1'b1, 2'h0), C_OK);
        w(A_CTRL, 32'h4);
        job(jw(J_IN, 8'h1, 1'b1, 2'h0), C_PU);
        w(A_CTRL, {29'h1, M_CPU});
        job(jw(J_DEL, 8'h1, 1'b1, 2'h0), C_PU);
        job(jw(J_OUT, 8'h9, 1'b0, 2'h0), C_NODS);
        job(jw(J_DEL, 8'h9, 1'b0, 2'h0), C_NODS);
        job(jw(J_IN, 8'h9, 1'b0, 2'h3), C_NODS);
        $display("mode test done");
        // Changes refused until the axis is completed and idle
        w(A_AXST, 32'h6);
        job(jw(J_IN, 8'h4, 1'b0, 2'h0), C_CHG);
        w(A_AXST, 32'hF);
        job(jw(J_IN, 8'h4, 1'b0, 2'h0), C_CHG);
        w(A_AXST, 32'h7);
        job(jw(J_IN, 8'h4, 1'b0, 2'h0), C_OK);
        job(jw(J_IN, 8'h5, 1'b0, 2'h1), C_OK);
        job(jw(J_OUT, 8'h5, 1'b0, 2'h0), C_OK);
        w(A_VAL0 + 8'(4 * V_RCUT), 32'h0);
        job(jw(J_IN, 8'h7, 1'b0, 2'h2), C_RCUT);
        rd(A_DATA);
        cmp("data", d, 32'h00050403);
        w(A_VAL0 + 8'(4 * V_RCUT), base[V_RCUT]);
        $display("change test done");
        // Deletion, with the host slow to take each write answer
        u_mdj_host.lag = 3;
        w(A_AXST, 32'h5);
        job(jw(J_DEL, 8'h5, 1'b0, 2'h0), C_DEL);
        w(A_AXST, 32'h47);
        job(jw(J_DEL, 8'h4, 1'b0, 2'h0), C_DEL);
        job(jw(J_DEL, 8'h5, 1'b0, 2'h0), C_OK);
        job(jw(J_DEL, 8'h4, 1'b0, 2'h0), C_OK);
        u_mdj_host.lag = 0;
        rd(A_DATA);
        cmp("held", {29'h0, d[2:0]}, 32'h0);
        $display("delete test done");
        // Discarded sets, then the interrupt raised, masked and cleared
        w(A_IRQST, 32'h7);
        w(A_IRQMSK, 32'h4);
        w(A_DEPS, 32'h3);
        job(jw(J_IN, 8'h4, 1'b0, 2'h0), C_DISC);
        cmp("count", {24'h0, d[15:8]}, 32'h3);
        rd(A_DEPS);
        cmp("deps", d, 32'h0);
        rd(A_IRQST);
        cmp("irqst", d, 32'h5);
        chkIrq(1'b1);
        w(A_IRQMSK, 32'h2);
        chkIrq(1'b0);
        job(jw(8'h10, 8'h4, 1'b0, 2'h0), C_JOB);
        chkIrq(1'b1);
        w(A_IRQST, 32'h2);
        chkIrq(1'b0);
        w(A_IRQMSK, 32'h4);
        chkIrq(1'b1);
        w(A_IRQST, 32'h4);
        chkIrq(1'b0);
        $display("interrupt test done");
        testDone();
    end
endmodule
`default_nettype wire
